/* fbc_top.sv */
// Byte-count, readiness and status-valid logic behind an AXI4-Lite register port
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns

// How it works
// - Capability bit selects fixed or dynamic counting
// - Dynamic send count tracks free command space
// - Dynamic read count tracks readable response bytes
// - Fixed count constant between module init events
// - Fixed send count zero until burst written
// - Fixed read count zero until burst read
// - Count nonzero quickly after ready or available
// - Two count bytes never mix two values
// - Latch both bytes on low read
// - Status valid set within short timeout
// - Status valid only in completion or reception
// - Ready field equals Ready state, FIFOs empty
// - First command byte clears ready field
// - Write zero, or one in Ready, ignored
// - Idle goes Ready within long timeout
// - Ready write during reception aborts command
// - Completion write flushes, Ready else Idle
// - Ready write during execution aborts execution
module fbc_top
  import fbc_pkg::*;
#(
  parameter int DEPTH         = FBC_FIFO_DEPTH,
  parameter int FIXED_COUNT   = FBC_FIXED_COUNT,
  parameter int SHORT_TIMEOUT = FBC_SHORT_TIMEOUT,
  parameter int LONG_TIMEOUT  = FBC_LONG_TIMEOUT
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        module_init_event,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Firmware side of the command FIFO
  output logic [7:0]       cmd_byte,
  output logic             cmd_byte_push,
  input  wire logic        fw_cmd_pop,
  // Firmware side of the response FIFO
  input  wire logic [7:0]  fw_rsp_head,
  input  wire logic        fw_rsp_push,
  output logic             rsp_byte_pop,
  // Firmware sequencing
  input  wire logic        fw_exec_start,
  input  wire logic        fw_response_done,
  output logic             fifo_flush,
  output logic             exec_abort,
  output logic [2:0]       state_out
);

  localparam int LW = $clog2(DEPTH + 1);
  localparam int TW = $clog2(LONG_TIMEOUT + SHORT_TIMEOUT + 1);
  localparam logic [LW-1:0] DEPTH_L = LW'(DEPTH);
  localparam logic [LW-1:0] FIXED_L = LW'(FIXED_COUNT);

  // Low two address bits ignored: every register owns one word
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  fbc_state_t state_q, state_d;
  logic [LW-1:0] cmd_lvl_q, rsp_lvl_q;
  logic [LW-1:0] burst_left_q;
  logic          burst_busy_q;
  logic          fixed_sel_q;
  logic          sts_valid_q;
  logic [TW-1:0] sts_tmr_q;
  logic [TW-1:0] idle_tmr_q;
  logic          idle_wait_q;
  logic [15:0]   cnt_latch_q;
  logic          latch_ok_q;
  logic          bvalid_q, rvalid_q;
  logic [1:0]    bresp_q, rresp_q;
  logic [31:0]   rdata_q;
  logic [7:0]    cmd_byte_q;
  logic          cmd_push_q, rsp_pop_q, flush_q, abort_q;

  // Write decode; a data write to a full command FIFO waits on the bus
  wire aw_both    = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire wr_data    = hit(s_axi_awaddr, FBC_DATA_OFS);
  wire cmd_full   = cmd_lvl_q == DEPTH_L;
  wire send_phase = (state_q == FBC_READY) || (state_q == FBC_RECEPTION);
  wire wr_go      = aw_both && !(wr_data && cmd_full);
  wire wr_sts     = wr_go && hit(s_axi_awaddr, FBC_STATUS_OFS) && s_axi_wstrb[0];
  wire wr_cap     = wr_go && hit(s_axi_awaddr, FBC_CAP_OFS) && s_axi_wstrb[0];
  wire host_push  = wr_go && wr_data && s_axi_wstrb[0] && send_phase;
  wire wr_known   = wr_data || hit(s_axi_awaddr, FBC_STATUS_OFS) || hit(s_axi_awaddr, FBC_CAP_OFS)
                    || hit(s_axi_awaddr, FBC_COUNT_LO_OFS) || hit(s_axi_awaddr, FBC_COUNT_HI_OFS);
  wire rdy_write  = wr_sts && s_axi_wdata[FBC_STS_READY_BIT];   // Zero writes fall away

  // Read decode
  wire rd_go      = s_axi_arvalid && !rvalid_q;
  wire rd_sts     = rd_go && hit(s_axi_araddr, FBC_STATUS_OFS);
  wire rd_lo      = rd_go && hit(s_axi_araddr, FBC_COUNT_LO_OFS);
  wire rd_hi      = rd_go && hit(s_axi_araddr, FBC_COUNT_HI_OFS);
  wire rd_cap     = rd_go && hit(s_axi_araddr, FBC_CAP_OFS);
  wire rd_data    = rd_go && hit(s_axi_araddr, FBC_DATA_OFS);
  wire rsp_avail  = (state_q == FBC_COMPLETION) && (rsp_lvl_q != '0);
  wire host_pop   = rd_data && rsp_avail;
  wire data_acc   = host_push || rd_data || (wr_go && wr_data);

  // Flush requests from the ready field
  wire flush_now  = rdy_write && (state_q != FBC_READY);
  wire both_empty = (cmd_lvl_q == '0) && (rsp_lvl_q == '0);

  // Live count in both modes
  logic [LW-1:0] dyn_cnt, fix_cnt, live_cnt;
  // Fixed mode: too little room for a whole burst reads zero, never a short count
  assign dyn_cnt = send_phase ? DEPTH_L - cmd_lvl_q
                 : rsp_lvl_q;
  assign fix_cnt = burst_busy_q ? '0
                 : send_phase ? ((DEPTH_L - cmd_lvl_q >= FIXED_L) ? FIXED_L : '0)
                 : ((rsp_lvl_q >= FIXED_L) ? FIXED_L : '0);
  // Count is combinational, so in dynamic mode it is nonzero the cycle space or data exists
  assign live_cnt = (!send_phase && !rsp_avail) ? '0
                  : fixed_sel_q ? fix_cnt : dyn_cnt;
  wire [15:0] live16 = 16'(live_cnt);

  // Command state machine
  // Execution and Completion move only on firmware strobes or a ready write
  always_comb begin
    state_d = state_q;
    case (state_q)
      FBC_IDLE: begin
        if (idle_wait_q && both_empty) begin
          state_d = FBC_READY;
        end
      end
      FBC_READY: begin
        if (host_push) begin
          state_d = FBC_RECEPTION;
        end
      end
      FBC_RECEPTION: begin
        if (flush_now) begin
          state_d = FBC_IDLE;
        end else if (fw_exec_start) begin
          state_d = FBC_EXECUTION;
        end
      end
      FBC_EXECUTION: begin
        if (flush_now) begin
          state_d = FBC_IDLE;
        end else if (fw_response_done) begin
          state_d = FBC_COMPLETION;
        end
      end
      FBC_COMPLETION: begin
        if (flush_now) begin
          state_d = FBC_IDLE;
        end
      end
      default: state_d = FBC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || module_init_event) begin
      state_q     <= FBC_IDLE;
      idle_wait_q <= 1'b0;
      idle_tmr_q  <= '0;
    end else begin
      state_q <= state_d;
      // Idle waits for both FIFOs empty, gives up after the long limit
      // Giving up keeps a stuck firmware from holding the ready request forever
      if (flush_now || (rdy_write && state_q == FBC_IDLE)) begin
        idle_wait_q <= 1'b1;
        idle_tmr_q  <= TW'(LONG_TIMEOUT);
      end else if (state_d == FBC_READY || idle_tmr_q == '0) begin
        idle_wait_q <= 1'b0;
      end else begin
        idle_tmr_q <= idle_tmr_q - 1'b1;
      end
    end
  end

  // FIFO fill levels; flush wins over same-cycle traffic
  always_ff @(posedge aclk) begin
    if (!aresetn || module_init_event || flush_q) begin
      cmd_lvl_q <= '0;
      rsp_lvl_q <= '0;
    end else begin
      cmd_lvl_q <= cmd_lvl_q + LW'(host_push) - LW'(fw_cmd_pop && cmd_lvl_q != '0);
      rsp_lvl_q <= rsp_lvl_q + LW'(fw_rsp_push && rsp_lvl_q != DEPTH_L) - LW'(host_pop);
    end
  end

  // Fixed-mode burst tracker: zero from first byte until the burst completes
  always_ff @(posedge aclk) begin
    if (!aresetn || module_init_event || flush_q) begin
      burst_busy_q <= 1'b0;
      burst_left_q <= '0;
    end else if (fixed_sel_q && (host_push || host_pop)) begin
      if (!burst_busy_q && FIXED_L > 1) begin
        burst_busy_q <= 1'b1;
        burst_left_q <= FIXED_L - 1'b1;
      end else if (burst_left_q <= 1) begin
        burst_busy_q <= 1'b0;
        burst_left_q <= '0;
      end else begin
        burst_left_q <= burst_left_q - 1'b1;
      end
    end
  end

  // Capability bit, kept across bus activity until reset
  // Writable only in Idle, so the fixed count cannot move mid-command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fixed_sel_q <= FBC_CAP_FIXED_RST;
    end else if (wr_cap && state_q == FBC_IDLE) begin
      fixed_sel_q <= s_axi_wdata[FBC_CAP_FIXED_BIT];
    end
  end

  // Status-valid: cleared by a status access, set again after a short settle
  // Limitation: a poll tighter than the settle time never sees the flag set
  wire sts_ok = (state_q == FBC_COMPLETION) || (state_q == FBC_RECEPTION);
  always_ff @(posedge aclk) begin
    if (!aresetn || module_init_event) begin
      sts_valid_q <= 1'b0;
      sts_tmr_q   <= '0;
    end else if (rd_sts || (wr_go && hit(s_axi_awaddr, FBC_STATUS_OFS))) begin
      sts_valid_q <= 1'b0;
      sts_tmr_q   <= TW'(SHORT_TIMEOUT);
    end else if (sts_tmr_q > 1) begin
      sts_tmr_q <= sts_tmr_q - 1'b1;
    end else begin
      sts_tmr_q   <= '0;
      sts_valid_q <= sts_ok;
    end
  end

  // Count latch taken on the low read, dropped by any data access
  // Without the latch the live high byte is read, zero unless DEPTH exceeds 255
  always_ff @(posedge aclk) begin
    if (!aresetn || module_init_event || data_acc) begin
      latch_ok_q  <= 1'b0;
      cnt_latch_q <= '0;
    end else if (rd_lo) begin
      latch_ok_q  <= 1'b1;
      cnt_latch_q <= live16;
    end
  end

  // Read data selection
  logic [31:0] rd_word;
  logic        rd_known;
  always_comb begin
    rd_word  = '0;
    rd_known = 1'b1;
    if (rd_sts) begin
      rd_word[FBC_STS_VALID_BIT]  = sts_valid_q;
      rd_word[FBC_STS_READY_BIT]  = state_q == FBC_READY;
      rd_word[FBC_STS_AVAIL_BIT]  = rsp_avail;
      rd_word[FBC_STS_EXPECT_BIT] = state_q == FBC_RECEPTION;
    end else if (rd_lo) begin
      rd_word[7:0] = live16[7:0];
    end else if (rd_hi) begin
      rd_word[7:0] = latch_ok_q ? cnt_latch_q[15:8] : live16[15:8];
    end else if (rd_cap) begin
      rd_word[FBC_CAP_FIXED_BIT] = fixed_sel_q;
    end else if (rd_data) begin
      rd_word[7:0] = rsp_avail ? fw_rsp_head : FBC_EMPTY_BYTE;
    end else begin
      rd_known = 1'b0;
    end
  end

  // Bus answers and firmware strobes
  // One transfer per channel in flight; the answer comes one cycle after taking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q   <= 1'b0;
      bresp_q    <= FBC_RESP_OKAY;
      rvalid_q   <= 1'b0;
      rresp_q    <= FBC_RESP_OKAY;
      rdata_q    <= '0;
      cmd_byte_q <= '0;
      cmd_push_q <= 1'b0;
      rsp_pop_q  <= 1'b0;
      flush_q    <= 1'b0;
      abort_q    <= 1'b0;
    end else begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_known ? FBC_RESP_OKAY : FBC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= rd_known ? FBC_RESP_OKAY : FBC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      cmd_push_q <= host_push;
      if (host_push) begin
        cmd_byte_q <= s_axi_wdata[7:0];
      end
      rsp_pop_q <= host_pop;
      flush_q   <= flush_now;
      abort_q   <= flush_now && (state_q == FBC_EXECUTION || state_q == FBC_RECEPTION);
    end
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign cmd_byte      = cmd_byte_q;
  assign cmd_byte_push = cmd_push_q;
  assign rsp_byte_pop  = rsp_pop_q;
  assign fifo_flush    = flush_q;
  assign exec_abort    = abort_q;
  assign state_out     = state_q;

endmodule

/* fbc_pkg.sv */
// Package with register map, field positions and states of the byte-count block
package fbc_pkg;

  // Register byte addresses
  localparam logic [7:0] FBC_STATUS_OFS    = 8'h00;
  localparam logic [7:0] FBC_COUNT_LO_OFS  = 8'h04;
  localparam logic [7:0] FBC_COUNT_HI_OFS  = 8'h08;
  localparam logic [7:0] FBC_CAP_OFS       = 8'h0C;
  localparam logic [7:0] FBC_DATA_OFS      = 8'h10;

  // Status register fields
  localparam int FBC_STS_EXPECT_BIT  = 3;
  localparam int FBC_STS_AVAIL_BIT   = 4;
  localparam int FBC_STS_READY_BIT   = 6;
  localparam int FBC_STS_VALID_BIT   = 7;

  // Capability register fields
  localparam int FBC_CAP_FIXED_BIT   = 0;
  localparam logic FBC_CAP_FIXED_RST = 1'b0;

  // Defaults of counts and timeouts
  localparam int FBC_FIFO_DEPTH      = 64;
  localparam int FBC_FIXED_COUNT     = 16;
  localparam int FBC_SHORT_TIMEOUT   = 8;
  localparam int FBC_LONG_TIMEOUT    = 64;

  // Bus answers and empty read value
  localparam logic [1:0] FBC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FBC_RESP_SLVERR = 2'h2;
  localparam logic [7:0] FBC_EMPTY_BYTE  = 8'hFF;

  typedef enum logic [2:0] {
    FBC_IDLE      = 3'b000,
    FBC_READY     = 3'b001,
    FBC_RECEPTION = 3'b010,
    FBC_EXECUTION = 3'b011,
    FBC_COMPLETION= 3'b100
  } fbc_state_t;

endpackage

/* fbc_monitor.sv */
// Checker of port timing and state moves of the byte-count block
`timescale 1ns/1ns
module fbc_monitor
  import fbc_pkg::*;
#(
  parameter int LONG_TIMEOUT = FBC_LONG_TIMEOUT
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register port
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // Firmware side
  input wire logic        cmd_byte_push,
  input wire logic        fifo_flush,
  input wire logic        exec_abort,
  input wire logic [2:0]  state_out
);
  // Margin over the long limit for the flush pass through Idle
  localparam int LT = LONG_TIMEOUT + 4;
  logic sts_rd_q;
  wire  wr_go  = s_axi_awvalid && s_axi_awready;
  wire  sts_wr = wr_go && s_axi_awaddr == FBC_STATUS_OFS;
  always_ff @(posedge aclk) begin
    if (!aresetn) sts_rd_q <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready) sts_rd_q <= s_axi_araddr == FBC_STATUS_OFS;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_ANSWER: assert property (wr_go |=> s_axi_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_PUSH_LEAVES_READY: assert property (cmd_byte_push |-> state_out != FBC_READY)
    else $error("ready kept after command byte");
  AST_ZERO_WRITE: assert property (sts_wr && !s_axi_wdata[FBC_STS_READY_BIT] &&
    state_out == FBC_IDLE |=> state_out == FBC_IDLE)
    else $error("zero write changed state");
  AST_READY_WRITE: assert property (sts_wr && s_axi_wdata[FBC_STS_READY_BIT] &&
    state_out == FBC_READY |=> state_out == FBC_READY)
    else $error("ready write left ready");
  AST_IDLE_TO_READY: assert property (sts_wr && s_axi_wdata[FBC_STS_READY_BIT] &&
    state_out == FBC_IDLE |-> ##[1:LT] state_out == FBC_READY)
    else $error("idle did not reach ready");
  AST_ABORT_FLUSH: assert property (exec_abort |-> ##[0:2] fifo_flush)
    else $error("abort without flush");
  AST_DONE_FLUSH: assert property (sts_wr && s_axi_wdata[FBC_STS_READY_BIT] &&
    state_out == FBC_COMPLETION |-> ##[1:3] fifo_flush)
    else $error("completion write without flush");
  AST_FLUSH_READY: assert property (fifo_flush |-> ##[1:LT] state_out == FBC_READY)
    else $error("flush did not reach ready");
  AST_VALID_STATE: assert property (s_axi_rvalid && sts_rd_q && s_axi_rdata[FBC_STS_VALID_BIT] |->
    state_out inside {FBC_RECEPTION, FBC_COMPLETION})
    else $error("status valid in wrong state");
endmodule
bind fbc_top fbc_monitor #(.LONG_TIMEOUT(LONG_TIMEOUT)) u_fbc_monitor (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .cmd_byte_push, .fifo_flush, .exec_abort, .state_out);

/* fbc_fw_model.sv */
// Firmware model that drains commands and feeds responses
`timescale 1ns/1ns
module fbc_fw_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bench controls
  input  wire logic       drain,
  input  wire logic       go,
  input  wire logic [7:0] rsp_n,
  // Block side
  input  wire logic       cmd_byte_push,
  input  wire logic       rsp_byte_pop,
  output logic            fw_cmd_pop,
  output logic            fw_rsp_push,
  output logic [7:0]      fw_rsp_head,
  output logic            fw_exec_start,
  output logic            fw_response_done
);
  logic [7:0] pend_q;
  logic [7:0] left_q;
  logic [7:0] hd_q;
  wire  [7:0] pend_d = pend_q + 8'(cmd_byte_push) - 8'(fw_cmd_pop);
  // Head moves on every pop, so a stale byte is never read twice
  assign fw_rsp_head = 8'hA0 + hd_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pend_q, left_q, hd_q} <= '0;
      {fw_cmd_pop, fw_rsp_push, fw_exec_start, fw_response_done} <= '0;
    end else begin
      pend_q <= pend_d;
      fw_cmd_pop <= drain && pend_d != 8'h00;
      fw_exec_start <= go;
      fw_rsp_push <= left_q != 8'h00;
      fw_response_done <= left_q == 8'h01;
      left_q <= go ? rsp_n : left_q - 8'(left_q != 8'h00);
      hd_q <= go ? 8'h00 : hd_q + 8'(rsp_byte_pop);
    end
  end
endmodule

/* tb_fbc_top.sv */
// Self-checking bench of the byte-count block
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_fbc_top;
  import fbc_pkg::*;
  localparam int DP = 16;
  localparam int FX = 4;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, m, e; logic [1:0] r;} fbc_row_t;
  logic aclk = 0, aresetn = 0, module_init_event = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rsp_n = 0, cmd_byte, fw_rsp_head;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic drain = 0, go = 0, s_axi_bready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cmd_byte_push, fw_cmd_pop, fw_rsp_push, rsp_byte_pop, fw_exec_start, fw_response_done, fifo_flush, exec_abort;
  logic [2:0] state_out;
  int errors = 0, n_checks = 0, cycles = 0, aborts = 0, bwait = 0;
  fbc_row_t rows [12] = '{
    '{0, FBC_CAP_OFS, 0, 32'h1, 32'h0, FBC_RESP_OKAY},
    '{1, FBC_STATUS_OFS, 0, 0, 0, FBC_RESP_OKAY},
    '{0, FBC_COUNT_LO_OFS, 0, 32'hFF, 32'h0, FBC_RESP_OKAY},
    '{1, FBC_STATUS_OFS, 32'h40, 0, 0, FBC_RESP_OKAY},
    '{0, FBC_STATUS_OFS, 0, 32'h40, 32'h40, FBC_RESP_OKAY},
    '{0, FBC_COUNT_LO_OFS, 0, 32'hFF, DP, FBC_RESP_OKAY},
    '{1, FBC_STATUS_OFS, 32'h40, 0, 0, FBC_RESP_OKAY},
    '{0, FBC_STATUS_OFS, 0, 32'h40, 32'h40, FBC_RESP_OKAY},
    '{0, 8'h20, 0, 32'hFFFFFFFF, 32'h0, FBC_RESP_SLVERR},
    '{1, 8'h20, 32'h1, 0, 0, FBC_RESP_SLVERR},
    '{0, FBC_COUNT_HI_OFS, 0, 32'hFF, 32'h0, FBC_RESP_OKAY},
    '{0, FBC_DATA_OFS, 0, 32'hFF, 32'hFF, FBC_RESP_OKAY}};
  fbc_top #(.DEPTH(DP), .FIXED_COUNT(FX), .SHORT_TIMEOUT(4), .LONG_TIMEOUT(16)) u_fbc_top (.aclk, .aresetn,
    .module_init_event, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .cmd_byte, .cmd_byte_push,
    .fw_cmd_pop, .fw_rsp_head, .fw_rsp_push, .rsp_byte_pop, .fw_exec_start, .fw_response_done, .fifo_flush,
    .exec_abort, .state_out);
  fbc_fw_model u_fbc_fw_model (.aclk, .aresetn, .drain, .go, .rsp_n, .cmd_byte_push, .rsp_byte_pop, .fw_cmd_pop,
    .fw_rsp_push, .fw_rsp_head, .fw_exec_start, .fw_response_done);
  always #10 aclk = ~aclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Each write channel drops at its own ready; bwait holds bready low to stall the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 0;
    w_done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    if (bwait > 0) s_axi_bready <= 0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1;
        s_axi_awvalid <= 0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1;
        s_axi_wvalid <= 0;
      end
    end
    if (bwait > 0) begin
      repeat (bwait) @(posedge aclk);
      s_axi_bready <= 1;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, rd_d, rs);
    `CHK(rd_d & m, e)
  endtask
  task automatic pulse_go(input logic [7:0] n);
    rsp_n <= n;
    go <= 1;
    cyc(1);
    go <= 0;
    cyc(40);
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (exec_abort === 1'b1) aborts++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    cyc(16);
    aresetn <= 1;
    cyc(1);
    `CHK(state_out, FBC_IDLE)
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rs);
      else rchk(rows[i].a, rows[i].m, rows[i].e);
      `CHK(rs, rows[i].r)
      cyc(24);
    end
    for (int i = 0; i < 3; i++) wr(FBC_DATA_OFS, 32'h51 + i, rs);
    `CHK(cmd_byte, 8'h53)
    `CHK(state_out, FBC_RECEPTION)
    rchk(FBC_COUNT_LO_OFS, 32'hFF, 32'(DP - 3));
    drain <= 1;
    cyc(10);
    rchk(FBC_COUNT_LO_OFS, 32'hFF, DP);
    wr(FBC_STATUS_OFS, 32'h40, rs);
    cyc(24);
    `CHK(aborts, 1)
    `CHK(state_out, FBC_READY)
    rchk(FBC_COUNT_LO_OFS, 32'hFF, DP);
    // Abort while firmware executes; no response bytes are queued
    wr(FBC_DATA_OFS, 32'h70, rs);
    pulse_go(8'd0);
    `CHK(state_out, FBC_EXECUTION)
    wr(FBC_STATUS_OFS, 32'h40, rs);
    cyc(24);
    `CHK(aborts, 2)
    `CHK(state_out, FBC_READY)
    // Ready write with a stalled answer; state must stay Ready
    bwait = 3;
    wr(FBC_STATUS_OFS, 32'h40, rs);
    bwait = 0;
    `CHK(rs, FBC_RESP_OKAY)
    `CHK(state_out, FBC_READY)
    wr(FBC_DATA_OFS, 32'h77, rs);
    cyc(4);
    pulse_go(8'd5);
    `CHK(state_out, FBC_COMPLETION)
    rd(FBC_STATUS_OFS, rd_d, rs);
    cyc(12);
    rchk(FBC_STATUS_OFS, 32'h90, 32'h90);
    rchk(FBC_COUNT_LO_OFS, 32'hFF, 32'd5);
    rchk(FBC_DATA_OFS, 32'hFF, 32'hA0);
    rchk(FBC_COUNT_LO_OFS, 32'hFF, 32'd4);
    rchk(FBC_COUNT_HI_OFS, 32'hFF, 32'd0);
    wr(FBC_STATUS_OFS, 32'h40, rs);
    cyc(24);
    rchk(FBC_STATUS_OFS, 32'h40, 32'h40);
    `CHK(aborts, 2)
    module_init_event <= 1;
    cyc(2);
    module_init_event <= 0;
    cyc(2);
    `CHK(state_out, FBC_IDLE)
    wr(FBC_CAP_OFS, 32'h1, rs);
    rchk(FBC_CAP_OFS, 32'h1, 32'h1);
    wr(FBC_STATUS_OFS, 32'h40, rs);
    cyc(24);
    rchk(FBC_COUNT_LO_OFS, 32'hFF, FX);
    rchk(FBC_STATUS_OFS, 32'h40, 32'h40);
    wr(FBC_DATA_OFS, 32'h61, rs);
    rchk(FBC_COUNT_LO_OFS, 32'hFF, 32'd0);
    for (int i = 0; i < FX - 1; i++) wr(FBC_DATA_OFS, 32'h62 + i, rs);
    cyc(8);
    rchk(FBC_COUNT_LO_OFS, 32'hFF, FX);
    pulse_go(8'd8);
    rchk(FBC_COUNT_LO_OFS, 32'hFF, FX);
    rd(FBC_DATA_OFS, rd_d, rs);
    rchk(FBC_COUNT_LO_OFS, 32'hFF, 32'd0);
    for (int i = 0; i < FX - 1; i++) rd(FBC_DATA_OFS, rd_d, rs);
    rchk(FBC_COUNT_LO_OFS, 32'hFF, FX);
    wr(FBC_STATUS_OFS, 32'h40, rs);
    cyc(24);
    aresetn <= 0;
    cyc(16);
    aresetn <= 1;
    cyc(2);
    `CHK(state_out, FBC_IDLE)
    rchk(FBC_CAP_OFS, 32'h1, 32'h0);
    test_done();
  end
endmodule
